/* ffs_supervisor.sv */
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
// Operation
// - Boost enabled at bias turn-on level, disabled below turn-off level.
// - No boost switching while bias input is at or above disable level.
// - In peak-current mode next cycle starts after a zero crossing.
// - Missing zero crossing: next cycle only after the 700 us timer.
// - Peak-current mode ends on-time when peak comparator trips.
// - Off-time mode trip after blanking blocks new cycle for 4.35 us.
// - First option: every fault auto-recovers, never latches.
// - Second option latches output OV, power, current, short, current-sense and thermistor OTP faults.
// - Third option latches only output OV and thermistor overtemperature.
// - Latched state holds until supply reset or a line zero crossing after line loss.
// - Line back within 2 s of loss clears latch and restarts.
// - Over-power after 160 ms; timed restart waits 1.5 s.
// - Overcurrent on three low-side pulses, response by option.
// - Output overvoltage on three low-side pulses, response by option.
// - Short circuit when supply at turn-off with power or low-aux flag.
// - Thermistor fault after 50 us; auto set holds until release.
// - Current-sense overtemperature on two high-side pulses.
// - Input overvoltage after 750 us; holds until pin below release.
// - Start check ignores first pulse; three low pulses force restart.
// - Brown-out after 60 ms plus three confirming low pulses.
module ffs_supervisor #(
  parameter int ZCD_WAIT_CYC_P = ffs_pkg::ZCD_WAIT_CYC,
  parameter int OPP_CYC_P = ffs_pkg::OPP_CYC,
  parameter int FDR_CYC_P = ffs_pkg::FDR_CYC,
  parameter int NTC_CYC_P = ffs_pkg::NTC_CYC,
  parameter int INPUT_OVERVOLTAGE_FAULT_CYC_P = ffs_pkg::INPUT_OVERVOLTAGE_FAULT_CYC,
  parameter int BO_CYC_P = ffs_pkg::BO_CYC,
  parameter int LINE_LOSS_CYC_P = ffs_pkg::LINE_LOSS_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWriteData,
  input wire logic [3:0] avByteEnable,
  output logic [31:0] avReadData,
  output logic avWaitRequest,
  input wire logic binAboveOn,
  input wire logic binAboveOff,
  input wire logic binAboveDis,
  input wire logic bswBelowBin,
  input wire logic boostPeakTrip,
  input wire logic cotMode,
  input wire logic lowSidePulse,
  input wire logic highSidePulse,
  input wire logic ocpCmp,
  input wire logic ovpCmp,
  input wire logic csOtpCmp,
  input wire logic tsdCmp,
  input wire logic oppCmp,
  input wire logic pplCmp,
  input wire logic vddAtOff,
  input wire logic auxLowCmp,
  input wire logic ntcCmp,
  input wire logic ntcRelease,
  input wire logic iovpCmp,
  input wire logic fltBelowRelease,
  input wire logic vddBelowReset,
  input wire logic startCycle,
  input wire logic lineRunOk,
  input wire logic lineStopLow,
  input wire logic lineLost,
  input wire logic lineZeroCross,
  output logic boostGate,
  output logic switchEnable,
  output logic uvloRequest
);

  localparam int W = ffs_pkg::TW;
  localparam int NF = ffs_pkg::NUM_FAULTS;
  localparam int NQ = 4;

  // ****************************************
  // Bias regulator boost control
  // ****************************************
  logic biasEn_r;
  logic boostRun;
  ffs_pkg::ffs_boost_t bs_r;
  ffs_pkg::ffs_boost_t bsNxt;
  logic [W-1:0] bCnt_r;
  logic blankDone;
  logic zcdTimeout;
  logic boostGate_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      biasEn_r <= 1'b0;
    end else if (binAboveOn) begin
      biasEn_r <= 1'b1;
    end else if (!binAboveOff) begin
      biasEn_r <= 1'b0;
    end
  end

  assign boostRun = biasEn_r && !binAboveDis;
  // Trips inside blanking are switching noise, not current
  assign blankDone = bCnt_r >= W'(ffs_pkg::BLANK_CYC);

  always_comb begin
    bsNxt = bs_r;
    zcdTimeout = 1'b0;
    case (bs_r)
      ffs_pkg::BS_IDLE: begin
        if (boostRun) bsNxt = ffs_pkg::BS_ON;
      end
      ffs_pkg::BS_ON: begin
        if (!boostRun) begin
          bsNxt = ffs_pkg::BS_IDLE;
        end else if (boostPeakTrip && blankDone) begin
          bsNxt = cotMode ? ffs_pkg::BS_HOLD : ffs_pkg::BS_WAIT_ZCD;
        end
      end
      ffs_pkg::BS_WAIT_ZCD: begin
        if (!boostRun) begin
          bsNxt = ffs_pkg::BS_IDLE;
        end else if (bswBelowBin) begin
          bsNxt = ffs_pkg::BS_ON;
        end else if (bCnt_r == W'(ZCD_WAIT_CYC_P - 1)) begin
          bsNxt = ffs_pkg::BS_ON;
          zcdTimeout = 1'b1;
        end
      end
      ffs_pkg::BS_HOLD: begin
        if (!boostRun) begin
          bsNxt = ffs_pkg::BS_IDLE;
        end else if (bCnt_r == W'(ffs_pkg::COT_HOLD_CYC - 1)) begin
          bsNxt = ffs_pkg::BS_IDLE;
        end
      end
      default: bsNxt = ffs_pkg::BS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bs_r <= ffs_pkg::BS_IDLE;
      bCnt_r <= '0;
      boostGate_r <= 1'b0;
    end else begin
      bs_r <= bsNxt;
      boostGate_r <= bsNxt == ffs_pkg::BS_ON;
      if (bsNxt != bs_r || zcdTimeout) begin
        bCnt_r <= '0;
      end else if (bCnt_r != '1) begin
        bCnt_r <= bCnt_r + 1'b1;
      end
    end
  end

  assign boostGate = boostGate_r;

  // ****************************************
  // Fault qualifiers
  // ****************************************
  logic [1:0] opt_r;
  ffs_pkg::ffs_state_t st_r;
  ffs_pkg::ffs_state_t stNxt;
  logic switchEn_r;
  logic [NF-1:0] faultEvt;
  logic [NQ-1:0] pqCond;
  logic [NQ-1:0] pqPulse;
  logic [NQ-1:0] pqFire;
  logic [NQ-1:0] tqCond;
  logic [NQ-1:0] tqFire;
  localparam int PQ_N [NQ] = '{ffs_pkg::OCP_PULSES, ffs_pkg::OVP_PULSES,
    ffs_pkg::CSOTP_PULSES, ffs_pkg::TSD_PULSES};
  localparam int TQ_N [NQ] = '{OPP_CYC_P, OPP_CYC_P, NTC_CYC_P, INPUT_OVERVOLTAGE_FAULT_CYC_P};

  assign pqCond = {tsdCmp, csOtpCmp, ovpCmp, ocpCmp};
  assign pqPulse = {lowSidePulse, highSidePulse, lowSidePulse, lowSidePulse};
  assign tqCond = {iovpCmp, ntcCmp, pplCmp, oppCmp};

  for (genvar g = 0; g < NQ; g++) begin : g_qual
    logic [2:0] pCnt_r;
    logic [W-1:0] tCnt_r;
    assign pqFire[g] = switchEn_r && pqPulse[g] && pqCond[g] &&
      pCnt_r == 3'(PQ_N[g] - 1);
    assign tqFire[g] = switchEn_r && tqCond[g] &&
      tCnt_r == W'(TQ_N[g] - 1);
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pCnt_r <= 3'h0;
      end else if (!switchEn_r) begin
        pCnt_r <= 3'h0;
      end else if (pqPulse[g]) begin
        pCnt_r <= (pqCond[g] && !pqFire[g]) ? pCnt_r + 3'h1 : 3'h0;
      end
    end
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        tCnt_r <= '0;
      end else if (!switchEn_r || !tqCond[g]) begin
        tCnt_r <= '0;
      end else if (!tqFire[g]) begin
        tCnt_r <= tCnt_r + 1'b1;
      end
    end
  end

  // ****************************************
  // Brown-in and brown-out
  // ****************************************
  logic biActive_r;
  logic biSeen_r;
  logic [1:0] biLow_r;
  logic biFault;
  logic boArmed_r;
  logic boExpired_r;
  logic [W-1:0] boCnt_r;
  logic [1:0] boConf_r;
  logic boFault;

  assign biFault = biActive_r && biSeen_r && lowSidePulse && !lineRunOk &&
    biLow_r == 2'(ffs_pkg::BI_PULSES - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      biActive_r <= 1'b0;
      biSeen_r <= 1'b0;
      biLow_r <= 2'h0;
    end else if (startCycle) begin
      biActive_r <= 1'b1;
      biSeen_r <= 1'b0;
      biLow_r <= 2'h0;
    end else if (biActive_r && lowSidePulse) begin
      if (!biSeen_r) begin
        biSeen_r <= 1'b1;
      end else if (lineRunOk || biFault) begin
        biActive_r <= 1'b0;
      end else begin
        biLow_r <= biLow_r + 2'h1;
      end
    end
  end

  // Timer may expire while switching pauses; pulses still have to confirm
  assign boFault = boExpired_r && lowSidePulse && lineStopLow &&
    boConf_r == 2'(ffs_pkg::BO_PULSES - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boArmed_r <= 1'b0;
      boExpired_r <= 1'b0;
      boCnt_r <= '0;
      boConf_r <= 2'h0;
    end else if ((lowSidePulse && !lineStopLow) || boFault) begin
      boArmed_r <= 1'b0;
      boExpired_r <= 1'b0;
      boCnt_r <= '0;
      boConf_r <= 2'h0;
    end else begin
      if (lowSidePulse && lineStopLow) boArmed_r <= 1'b1;
      if (boArmed_r && !boExpired_r) begin
        if (boCnt_r == W'(BO_CYC_P - 1)) begin
          boExpired_r <= 1'b1;
        end else begin
          boCnt_r <= boCnt_r + 1'b1;
        end
      end
      if (boExpired_r && lowSidePulse && lineStopLow) begin
        boConf_r <= boConf_r + 2'h1;
      end
    end
  end

  // ****************************************
  // Fault response
  // ****************************************
  logic holdNtc_r;
  logic holdIovp_r;
  logic lossSeen_r;
  logic [W-1:0] lossCnt_r;
  logic latchReset;
  logic [W-1:0] rcCnt_r;
  logic uvloReq_r;
  ffs_pkg::ffs_resp_t worst;

  function automatic ffs_pkg::ffs_resp_t respOf(input int idx,
                                                input logic [1:0] opt);
    ffs_pkg::ffs_resp_t r;
    logic grp;
    logic any;
    r = ffs_pkg::RESP_UVLO;
    grp = opt == ffs_pkg::OPT_GROUP_LATCH;
    any = opt != ffs_pkg::OPT_ALL_AUTO;
    case (idx)
      ffs_pkg::F_OVP: r = any ? ffs_pkg::RESP_LATCH : ffs_pkg::RESP_TIMED;
      ffs_pkg::F_NTC: r = any ? ffs_pkg::RESP_LATCH : ffs_pkg::RESP_UVLO;
      ffs_pkg::F_OPP, ffs_pkg::F_PPL, ffs_pkg::F_OCP, ffs_pkg::F_SCP,
      ffs_pkg::F_CSOTP: r = grp ? ffs_pkg::RESP_LATCH : ffs_pkg::RESP_TIMED;
      default: r = ffs_pkg::RESP_UVLO;
    endcase
    return r;
  endfunction

  always_comb begin
    faultEvt = '0;
    faultEvt[ffs_pkg::F_OCP] = pqFire[0];
    faultEvt[ffs_pkg::F_OVP] = pqFire[1];
    faultEvt[ffs_pkg::F_CSOTP] = pqFire[2];
    faultEvt[ffs_pkg::F_TSD] = pqFire[3];
    faultEvt[ffs_pkg::F_OPP] = tqFire[0];
    faultEvt[ffs_pkg::F_PPL] = tqFire[1];
    faultEvt[ffs_pkg::F_NTC] = tqFire[2];
    faultEvt[ffs_pkg::F_INPUT_OVERVOLTAGE_FAULT] = tqFire[3];
    faultEvt[ffs_pkg::F_SCP] = switchEn_r && vddAtOff &&
      (oppCmp || auxLowCmp);
    faultEvt[ffs_pkg::F_BI] = switchEn_r && biFault;
    faultEvt[ffs_pkg::F_BO] = switchEn_r && boFault;
  end

  always_comb begin
    worst = ffs_pkg::RESP_NONE;
    for (int i = 0; i < NF; i++) begin
      if (faultEvt[i] && respOf(i, opt_r) > worst) begin
        worst = respOf(i, opt_r);
      end
    end
  end

  // Loss time only runs while the line is reported absent
  assign latchReset = vddBelowReset || (lineZeroCross && lossSeen_r &&
    lossCnt_r < W'(LINE_LOSS_CYC_P));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lossSeen_r <= 1'b0;
      lossCnt_r <= '0;
    end else if (lineZeroCross) begin
      lossSeen_r <= 1'b0;
      lossCnt_r <= '0;
    end else if (lineLost) begin
      lossSeen_r <= 1'b1;
      if (lossCnt_r != W'(LINE_LOSS_CYC_P)) lossCnt_r <= lossCnt_r + 1'b1;
    end
  end

  // Set wins over release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      holdNtc_r <= 1'b0;
      holdIovp_r <= 1'b0;
    end else begin
      if (faultEvt[ffs_pkg::F_NTC] && opt_r == ffs_pkg::OPT_ALL_AUTO) begin
        holdNtc_r <= 1'b1;
      end else if (ntcRelease) begin
        holdNtc_r <= 1'b0;
      end
      if (faultEvt[ffs_pkg::F_INPUT_OVERVOLTAGE_FAULT]) begin
        holdIovp_r <= 1'b1;
      end else if (fltBelowRelease) begin
        holdIovp_r <= 1'b0;
      end
    end
  end

  always_comb begin
    stNxt = st_r;
    case (st_r)
      ffs_pkg::ST_RUN: begin
        case (worst)
          ffs_pkg::RESP_LATCH: stNxt = ffs_pkg::ST_LATCHED;
          ffs_pkg::RESP_TIMED: stNxt = ffs_pkg::ST_RECOVER;
          ffs_pkg::RESP_UVLO: stNxt = ffs_pkg::ST_UVLO_HOLD;
          default: stNxt = ffs_pkg::ST_RUN;
        endcase
      end
      ffs_pkg::ST_UVLO_HOLD: begin
        if (startCycle && !holdNtc_r && !holdIovp_r) stNxt = ffs_pkg::ST_RUN;
      end
      ffs_pkg::ST_RECOVER: begin
        if (rcCnt_r == W'(FDR_CYC_P - 1)) stNxt = ffs_pkg::ST_RUN;
      end
      ffs_pkg::ST_LATCHED: begin
        if (latchReset) stNxt = ffs_pkg::ST_RUN;
      end
      default: stNxt = ffs_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ffs_pkg::ST_RUN;
      switchEn_r <= 1'b1;
      uvloReq_r <= 1'b0;
      rcCnt_r <= '0;
    end else begin
      st_r <= stNxt;
      switchEn_r <= stNxt == ffs_pkg::ST_RUN;
      uvloReq_r <= stNxt == ffs_pkg::ST_UVLO_HOLD ||
        stNxt == ffs_pkg::ST_RECOVER;
      rcCnt_r <= (st_r == ffs_pkg::ST_RECOVER) ? rcCnt_r + 1'b1 : '0;
    end
  end

  assign switchEnable = switchEn_r;
  assign uvloRequest = uvloReq_r;

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  logic ack_r;
  logic wrEn;
  logic [31:0] wMask;
  logic [31:0] rdNxt;
  logic [31:0] rd_r;
  logic [ffs_pkg::STICKY_W-1:0] sticky_r;
  logic [ffs_pkg::STICKY_W-1:0] stickyClr;

  // One wait state on every access
  assign avWaitRequest = (avRead || avWrite) && !ack_r;
  assign wrEn = avWrite && ack_r;
  assign wMask = {{8{avByteEnable[3]}}, {8{avByteEnable[2]}},
    {8{avByteEnable[1]}}, {8{avByteEnable[0]}}};
  assign stickyClr = (wrEn && avAddress == ffs_pkg::REG_FAULT) ?
    avWriteData[ffs_pkg::STICKY_W-1:0] & wMask[ffs_pkg::STICKY_W-1:0] : '0;

  always_comb begin
    rdNxt = 32'h0;
    case (avAddress)
      ffs_pkg::REG_CTRL: rdNxt[1:0] = opt_r;
      ffs_pkg::REG_STATUS: rdNxt[7:0] = {holdIovp_r, holdNtc_r, boostGate_r,
        biasEn_r, st_r == ffs_pkg::ST_UVLO_HOLD, st_r == ffs_pkg::ST_RECOVER,
        st_r == ffs_pkg::ST_LATCHED, switchEn_r};
      ffs_pkg::REG_FAULT: rdNxt[ffs_pkg::STICKY_W-1:0] = sticky_r;
      default: rdNxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      rd_r <= 32'h0;
      opt_r <= ffs_pkg::CTRL_RST;
      sticky_r <= '0;
    end else begin
      ack_r <= (avRead || avWrite) && !ack_r;
      if (avRead && !ack_r) rd_r <= rdNxt;
      if (wrEn && avAddress == ffs_pkg::REG_CTRL && avByteEnable[0]) begin
        opt_r <= (avWriteData[1:0] > ffs_pkg::OPT_OVP_OTP_LATCH) ?
          ffs_pkg::OPT_ALL_AUTO : avWriteData[1:0];
      end
      sticky_r <= {zcdTimeout, faultEvt} | (sticky_r & ~stickyClr);
    end
  end

  assign avReadData = rd_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence seqCotTrip;
    bs_r == ffs_pkg::BS_ON && boostRun && boostPeakTrip && blankDone &&
      cotMode;
  endsequence
  sequence seqGateLow8;
    (!boostGate_r) [*8];
  endsequence
  sequence seqOvpLatchable;
    faultEvt[ffs_pkg::F_OVP] && opt_r != ffs_pkg::OPT_ALL_AUTO;
  endsequence

  AST_BIAS_OFF: assert property (!binAboveOn && !binAboveOff |=>
    !biasEn_r ##1 !boostGate_r) else $error("boost kept after bias off");
  AST_BOOST_DIS: assert property (binAboveDis |=> !boostGate_r)
    else $error("boost gate high above disable level");
  AST_ZCD_NEXT: assert property (bs_r == ffs_pkg::BS_WAIT_ZCD &&
    boostRun && bswBelowBin |=> boostGate_r)
    else $error("no cycle after zero crossing");
  AST_PEAK_END: assert property (bs_r == ffs_pkg::BS_ON && boostRun &&
    boostPeakTrip && blankDone && !cotMode |=> !boostGate_r)
    else $error("on-time not ended by peak trip");
  AST_COT_HOLD: assert property (seqCotTrip |=> seqGateLow8)
    else $error("cycle started inside off-time hold");
  AST_NO_LATCH: assert property (st_r != ffs_pkg::ST_LATCHED &&
    opt_r == ffs_pkg::OPT_ALL_AUTO |=> st_r != ffs_pkg::ST_LATCHED)
    else $error("latched under auto option");
  AST_OVP_LATCH: assert property (seqOvpLatchable |=>
    st_r == ffs_pkg::ST_LATCHED && !switchEnable)
    else $error("output overvoltage did not latch");
  AST_LATCH_HOLD: assert property (st_r == ffs_pkg::ST_LATCHED &&
    !latchReset |=> st_r == ffs_pkg::ST_LATCHED)
    else $error("latch left without reset event");
  AST_RECOVER_LEN: assert property ($rose(st_r == ffs_pkg::ST_RECOVER) |->
    (st_r == ffs_pkg::ST_RECOVER && uvloRequest) [*8])
    else $error("recovery time cut short");
  AST_SCP_STOP: assert property (switchEn_r && vddAtOff &&
    (oppCmp || auxLowCmp) |=> !switchEnable ##1 !switchEnable)
    else $error("short circuit not acted on");

endmodule // ffs_supervisor

/* ffs_pkg.sv */
package ffs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int NS_PER_US = 1000;
  localparam int US_PER_MS = 1000;
  localparam int TW = 28;
  localparam int BLANK_NS = 190;
  localparam int BLANK_CYC =
    (BLANK_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int COT_HOLD_NS = 4350;
  localparam int COT_HOLD_CYC =
    (COT_HOLD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int ZCD_WAIT_US = 700;
  localparam int ZCD_WAIT_CYC = ZCD_WAIT_US * CLK_MHZ;
  localparam int OPP_MS = 160;
  localparam int OPP_CYC = OPP_MS * US_PER_MS * CLK_MHZ;
  localparam int FDR_MS = 1500;
  localparam int FDR_CYC = FDR_MS * US_PER_MS * CLK_MHZ;
  localparam int NTC_US = 50;
  localparam int NTC_CYC = NTC_US * CLK_MHZ;
  localparam int INPUT_OVERVOLTAGE_FAULT_US = 750;
  localparam int INPUT_OVERVOLTAGE_FAULT_CYC = INPUT_OVERVOLTAGE_FAULT_US * CLK_MHZ;
  localparam int BO_MS = 60;
  localparam int BO_CYC = BO_MS * US_PER_MS * CLK_MHZ;
  localparam int LINE_LOSS_MS = 2000;
  localparam int LINE_LOSS_CYC = LINE_LOSS_MS * US_PER_MS * CLK_MHZ;

  // ****************************************
  // Pulse counts
  // ****************************************
  localparam int OCP_PULSES = 3;
  localparam int OVP_PULSES = 3;
  localparam int CSOTP_PULSES = 2;
  localparam int TSD_PULSES = 3;
  localparam int BI_PULSES = 3;
  localparam int BO_PULSES = 3;

  // ****************************************
  // Registers
  // ****************************************
  localparam int AW = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_FAULT = 4'h8;
  localparam logic [1:0] OPT_ALL_AUTO = 2'h0;
  localparam logic [1:0] OPT_GROUP_LATCH = 2'h1;
  localparam logic [1:0] OPT_OVP_OTP_LATCH = 2'h2;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // ****************************************
  // Fault indices
  // ****************************************
  localparam int F_OVP = 0;
  localparam int F_OPP = 1;
  localparam int F_PPL = 2;
  localparam int F_OCP = 3;
  localparam int F_SCP = 4;
  localparam int F_NTC = 5;
  localparam int F_CSOTP = 6;
  localparam int F_INPUT_OVERVOLTAGE_FAULT = 7;
  localparam int F_TSD = 8;
  localparam int F_BI = 9;
  localparam int F_BO = 10;
  localparam int NUM_FAULTS = 11;
  localparam int STICKY_W = NUM_FAULTS + 1;

  typedef enum logic [1:0] {RESP_NONE, RESP_UVLO, RESP_TIMED, RESP_LATCH}
    ffs_resp_t;
  typedef enum logic [1:0] {ST_RUN, ST_UVLO_HOLD, ST_RECOVER, ST_LATCHED}
    ffs_state_t;
  typedef enum logic [1:0] {BS_IDLE, BS_ON, BS_WAIT_ZCD, BS_HOLD}
    ffs_boost_t;

endpackage

/* ffs_stage.sv */
`timescale 1ns/1ns
// ****************************************
// Power stage stand-in
// ****************************************
module ffs_stage (
  input wire logic clk,
  input wire logic nrst,
  input wire logic switchEnable,
  input wire logic boostGate,
  input wire logic zcdOk,
  output logic lowSidePulse,
  output logic highSidePulse,
  output logic boostPeakTrip,
  output logic bswBelowBin
);
  logic [2:0] phase_r;
  logic [5:0] onCnt_r;
  logic [3:0] offCnt_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= 3'h0;
      onCnt_r <= 6'h00;
      offCnt_r <= 4'h0;
    end else begin
      phase_r <= phase_r + 3'h1;
      onCnt_r <= boostGate ? onCnt_r + 6'h01 : 6'h00;
      offCnt_r <= boostGate ? 4'h0 : offCnt_r + {3'h0, offCnt_r != 4'hF};
    end
  end
  // Gate pulses only while the converter may switch
  assign lowSidePulse = switchEnable && phase_r == 3'h0;
  assign highSidePulse = switchEnable && phase_r == 3'h4;
  // Peak lands well past blanking, so early trips are never tested here
  assign boostPeakTrip = boostGate && onCnt_r >= 6'h1E;
  // Crossing shows for one cycle only, so a missed one stays missed
  assign bswBelowBin = zcdOk && !boostGate && offCnt_r == 4'h8;
endmodule // ffs_stage

/* ffs_supervisor_tb.sv */
`timescale 1ns/1ns
module ffs_supervisor_tb;
  localparam int FDR = 60;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avAddress = 4'h0;
  logic avRead = 1'b0, avWrite = 1'b0;
  logic [31:0] avWriteData = 32'h0, avReadData, rd;
  logic [3:0] avByteEnable = 4'hF;
  logic avWaitRequest, boostGate, switchEnable, uvloRequest;
  logic binAboveOn = 1'b0, binAboveOff = 1'b0, binAboveDis = 1'b0;
  logic cotMode = 1'b0, zcdOk = 1'b1, lineLost = 1'b0;
  localparam int SC = 0, VR = 1, LZ = 2;
  logic [2:0] pls = 3'h0;
  wire startCycle = pls[SC];
  wire vddBelowReset = pls[VR];
  wire lineZeroCross = pls[LZ];
  logic lineRunOk = 1'b1, lineStopLow = 1'b0;
  logic lowSidePulse, highSidePulse, boostPeakTrip, bswBelowBin;
  logic [8:0] cmp = 9'h000;
  wire ovpCmp = cmp[0];
  wire ocpCmp = cmp[1];
  wire csOtpCmp = cmp[2];
  wire tsdCmp = cmp[3];
  wire oppCmp = cmp[4];
  wire ntcCmp = cmp[5];
  wire ntcRelease = !cmp[5];
  wire iovpCmp = cmp[6];
  wire fltBelowRelease = !cmp[6];
  wire vddAtOff = cmp[7];
  wire auxLowCmp = cmp[7];
  wire pplCmp = cmp[8];
  int numErrors = 0;
  int testsRun = 0;

  always #4 clk = ~clk;

  ffs_supervisor #(.ZCD_WAIT_CYC_P(50), .OPP_CYC_P(40), .FDR_CYC_P(FDR),
    .NTC_CYC_P(20), .INPUT_OVERVOLTAGE_FAULT_CYC_P(30), .BO_CYC_P(40), .LINE_LOSS_CYC_P(100))
    ffs_supervisor_i (.*);
  ffs_stage ffs_stage_i (.*);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic stopTest;
    $display("errors %0d checks %0d", numErrors, testsRun);
    if (numErrors == 0 && testsRun > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      numErrors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avAddress <= a;
    avWriteData <= d;
    avWrite <= w;
    avRead <= !w;
    @(posedge clk);
    while (avWaitRequest !== 1'b0) @(posedge clk);
    q = avReadData;
    avWrite <= 1'b0;
    avRead <= 1'b0;
    @(posedge clk);
  endtask

  task automatic setOpt(input logic [1:0] o);
    bus(1'b1, ffs_pkg::REG_CTRL, {30'h0, o}, rd);
  endtask

  task automatic pulse(input int k);
    pls[k] <= 1'b1;
    @(posedge clk);
    pls[k] <= 1'b0;
    @(posedge clk);
  endtask

  task automatic waitEn(input logic v);
    for (int n = 0; n < 80 && switchEnable !== v; n++) @(posedge clk);
  endtask

  task automatic waitGate(input logic v, output int n);
    for (n = 0; n < 900 && boostGate !== v; n++) @(posedge clk);
  endtask

  task automatic gap(output int hi, output int lo);
    waitGate(1'b1, lo);
    waitGate(1'b0, hi);
    waitGate(1'b1, lo);
  endtask

  task automatic quiet(input string nm);
    logic seen;
    seen = 1'b0;
    repeat (40) @(posedge clk);
    repeat (100) begin
      @(posedge clk);
      seen |= boostGate;
    end
    chk(nm, 32'h0, seen);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic tRegs;
    bus(1'b0, ffs_pkg::REG_CTRL, 32'h0, rd);
    chk("ctrl reset", 32'h0, rd);
    setOpt(2'h2);
    bus(1'b0, ffs_pkg::REG_CTRL, 32'h0, rd);
    chk("ctrl", 32'h2, rd);
    setOpt(2'h3);
    bus(1'b0, ffs_pkg::REG_CTRL, 32'h0, rd);
    chk("ctrl refused", 32'h0, rd);
    avByteEnable <= 4'hE;
    setOpt(2'h1);
    avByteEnable <= 4'hF;
    bus(1'b0, ffs_pkg::REG_CTRL, 32'h0, rd);
    chk("ctrl lane off", 32'h0, rd);
    bus(1'b0, 4'hC, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, ffs_pkg::REG_STATUS, 32'h0, rd);
    chk("status", 32'h1, rd & 32'h3);
  endtask

  task automatic tBoost;
    int hi, lo;
    binAboveOff <= 1'b1;
    binAboveOn <= 1'b1;
    waitGate(1'b1, lo);
    chk("boost start", 32'h1, lo < 10);
    gap(hi, lo);
    chk("on time", 32'h1, hi >= 24 && hi < 40);
    chk("zero cross gap", 32'h1, lo < 20);
    zcdOk <= 1'b0;
    gap(hi, lo);
    chk("missing cross", 32'h1, lo >= 50);
    cotMode <= 1'b1;
    gap(hi, lo);
    chk("off time hold", 32'h1, lo >= ffs_pkg::COT_HOLD_CYC);
    cotMode <= 1'b0;
    zcdOk <= 1'b1;
    binAboveDis <= 1'b1;
    quiet("disable level");
    binAboveDis <= 1'b0;
    binAboveOn <= 1'b0;
    binAboveOff <= 1'b0;
    quiet("turn off level");
  endtask

  // Each of the nine comparator faults alone, under each option: trip, hold, restart, clear
  task automatic tFaults;
    logic [8:0] lat;
    logic uv;
    for (int o = 0; o < 3; o++) begin
      lat = o == 0 ? 9'h000 : o == 1 ? 9'h1B7 : 9'h021;
      setOpt(o[1:0]);
      for (int f = 0; f < 9; f++) begin
        uv = f == 3 || f == 6 || (f == 5 && o == 0);
        cmp[f] <= 1'b1;
        waitEn(1'b0);
        chk("trip", 32'h0, switchEnable);
        cmp <= 9'h000;
        repeat (FDR - 10) @(posedge clk);
        chk("hold", 32'h0, switchEnable);
        chk("uvlo request", !lat[f], uvloRequest);
        repeat (20) @(posedge clk);
        chk("restart", !lat[f] && !uv, switchEnable);
        pulse(SC);
        repeat (3) @(posedge clk);
        chk("after start", !lat[f], switchEnable);
        pulse(VR);
        repeat (3) @(posedge clk);
        chk("supply reset", 32'h1, switchEnable);
      end
    end
  endtask

  task automatic tMulti;
    setOpt(2'h1);
    bus(1'b1, ffs_pkg::REG_FAULT, 32'hFFF, rd);
    cmp <= 9'h00A;
    waitEn(1'b0);
    cmp <= 9'h000;
    bus(1'b0, ffs_pkg::REG_FAULT, 32'h0, rd);
    chk("both flagged", 32'h108, rd);
    bus(1'b1, ffs_pkg::REG_FAULT, 32'h008, rd);
    bus(1'b0, ffs_pkg::REG_FAULT, 32'h0, rd);
    chk("one cleared", 32'h100, rd);
    repeat (FDR + 20) @(posedge clk);
    pulse(SC);
    repeat (3) @(posedge clk);
    chk("worst wins", 32'h0, switchEnable);
    pulse(VR);
    waitEn(1'b1);
  endtask

  task automatic tConsec;
    cmp <= 9'h002;
    repeat (2) @(posedge clk iff lowSidePulse);
    cmp <= 9'h000;
    @(posedge clk iff lowSidePulse);
    cmp <= 9'h002;
    repeat (2) @(posedge clk iff lowSidePulse);
    cmp <= 9'h000;
    repeat (2) @(posedge clk);
    chk("broken run", 32'h1, switchEnable);
  endtask

  task automatic tLine;
    setOpt(2'h2);
    for (int d = 0; d < 2; d++) begin
      cmp <= 9'h001;
      waitEn(1'b0);
      cmp <= 9'h000;
      pulse(LZ);
      repeat (FDR + 20) @(posedge clk);
      chk("cross alone", 32'h0, switchEnable);
      lineLost <= 1'b1;
      repeat (d * 140 + 5) @(posedge clk);
      lineLost <= 1'b0;
      pulse(LZ);
      repeat (3) @(posedge clk);
      chk("line back", d == 0, switchEnable);
      pulse(VR);
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic tSense;
    lineRunOk <= 1'b0;
    pulse(SC);
    waitEn(1'b0);
    chk("brown-in", 32'h0, switchEnable);
    lineRunOk <= 1'b1;
    pulse(SC);
    repeat (3) @(posedge clk);
    chk("brown-in clear", 32'h1, switchEnable);
    lineStopLow <= 1'b1;
    repeat (40) @(posedge clk);
    chk("brown-out early", 32'h1, switchEnable);
    waitEn(1'b0);
    chk("brown-out", 32'h0, switchEnable);
    lineStopLow <= 1'b0;
    pulse(SC);
    repeat (3) @(posedge clk);
    chk("brown-out clear", 32'h1, switchEnable);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    tRegs;
    tBoost;
    tFaults;
    tMulti;
    tConsec;
    tLine;
    tSense;
    stopTest;
  end

  // Whole run needs about 4500 cycles; this allows over five times that
  initial begin
    #200000;
    numErrors++;
    stopTest;
  end
endmodule // ffs_supervisor_tb
